// ### design/tpg_pkg.sv
package tpg_pkg;

    // =====================================================================
    // Bus geometry and answers
    localparam int TPG_ADDR_W = 12;
    localparam logic [1:0] TPG_RESP_OKAY = 2'h0;
    localparam logic [1:0] TPG_RESP_SLVERR = 2'h2;

    // =====================================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] TPG_IDX_VALUE_A = 8'hc0;
    localparam logic [7:0] TPG_IDX_VALUE_B = 8'hc1;
    localparam logic [7:0] TPG_IDX_VALUE_C = 8'hc2;
    localparam logic [7:0] TPG_IDX_DIR_A = 8'hc4;
    localparam logic [7:0] TPG_IDX_DIR_B = 8'hc5;
    localparam logic [7:0] TPG_IDX_DIR_C = 8'hc6;
    localparam logic [7:0] TPG_IDX_OPT_A = 8'hcc;
    localparam logic [7:0] TPG_IDX_OPT_B = 8'hcd;

    // =====================================================================
    // Storage slots of the register file
    localparam logic [2:0] TPG_SLOT_VALUE_A = 3'h0;
    localparam logic [2:0] TPG_SLOT_VALUE_B = 3'h1;
    localparam logic [2:0] TPG_SLOT_VALUE_C = 3'h2;
    localparam logic [2:0] TPG_SLOT_DIR_A = 3'h3;
    localparam logic [2:0] TPG_SLOT_DIR_B = 3'h4;
    localparam logic [2:0] TPG_SLOT_DIR_C = 3'h5;
    localparam logic [2:0] TPG_SLOT_OPT_A = 3'h6;
    localparam logic [2:0] TPG_SLOT_OPT_B = 3'h7;
    localparam int TPG_NUM_REGS = 8;

    // =====================================================================
    // Reset values
    localparam logic [7:0] TPG_RST_ZERO = 8'h00;
    localparam logic [7:0] TPG_RST_VALUE_C = 8'h04;
    localparam logic [7:0] TPG_RST_DIR_C = 8'h04;

    // =====================================================================
    // Per-line capability masks
    localparam logic [7:0] TPG_A_IRQ_MASK = 8'h3f;
    localparam logic [7:0] TPG_A_PP_MASK = 8'h3f;
    localparam logic [7:0] TPG_A_PU_MASK = 8'h3f;
    localparam logic [7:0] TPG_B_ALL_MASK = 8'hff;
    localparam logic [7:0] TPG_C_PU_MASK = 8'hfc;
    localparam logic [7:0] TPG_NONE_MASK = 8'h00;

    // =====================================================================
    // Carriers
    typedef struct packed {
        logic out;
        logic oe;
        logic pu;
        logic irq;
        logic ana;
    } tpg_line_type;

    typedef struct packed {
        logic hit;
        logic [2:0] slot;
    } tpg_sel_type;

    // Byte address to register slot
    function automatic tpg_sel_type tpg_decode(input logic [TPG_ADDR_W-1:0] addr);
        tpg_sel_type s;
        logic [7:0] idx;
        s = '0;
        idx = addr[9:2];
        if (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) begin
            s.hit = 1'b1;
            if (idx == TPG_IDX_VALUE_A) s.slot = TPG_SLOT_VALUE_A;
            else if (idx == TPG_IDX_VALUE_B) s.slot = TPG_SLOT_VALUE_B;
            else if (idx == TPG_IDX_VALUE_C) s.slot = TPG_SLOT_VALUE_C;
            else if (idx == TPG_IDX_DIR_A) s.slot = TPG_SLOT_DIR_A;
            else if (idx == TPG_IDX_DIR_B) s.slot = TPG_SLOT_DIR_B;
            else if (idx == TPG_IDX_DIR_C) s.slot = TPG_SLOT_DIR_C;
            else if (idx == TPG_IDX_OPT_A) s.slot = TPG_SLOT_OPT_A;
            else if (idx == TPG_IDX_OPT_B) s.slot = TPG_SLOT_OPT_B;
            else s.hit = 1'b0;
        end
        return s;
    endfunction : tpg_decode

    // Direction, option and value bits to line behaviour
    function automatic tpg_line_type tpg_line_cfg(
        input logic dir,
        input logic opt,
        input logic val,
        input logic irq_ok,
        input logic pp_ok,
        input logic ana_ok,
        input logic pu_ok
    );
        tpg_line_type c;
        c = '0;
        if (dir) begin
            if (opt && pp_ok) begin
                c.out = val;
                c.oe = 1'b1;
            end else begin
                c.oe = ~val;
            end
        end else if (!opt) begin
            c.pu = ~val & pu_ok;
        end else if (!val) begin
            c.pu = irq_ok;
            c.irq = irq_ok;
        end else begin
            c.ana = ana_ok;
        end
        return c;
    endfunction : tpg_line_cfg

endpackage : tpg_pkg

// ### design/tpg_gpio_top.sv
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
// Function
// - Three ports, each line input or output
// - Eight byte registers, bit n drives line n
// - Value read gives pins, write sets outputs
// - Input value bit selects input option
// - Per-port direction register, one bit per line
// - Direction zero input, one output
// - Option registers only for ports A and B
// - Reset clears registers, inputs with pull-up
// - Port C line two resets output high-Z
// - Pull-up per option and value, else high-Z
// - Enabled A/B interrupt lines ORed to vector one
// - Port B analog lines feed converter mux
// - Codes 000 pull-up, 001 plain input
// - Code 010 pull-up with interrupt
// - Port A code 011 plain input
// - Port B code 011 analog input
// - Output: option zero open-drain, one push-pull
// - Interrupt option only A0-A5 and port B
// - Push-pull only A0-A5 and port B
// - Port C pull-up on 2-7, open-drain outputs
// - A6-A7 two-wire, C0/C1/C3 display serial
// - C6/C7 horizontal timing, C4 power-in
module tpg_gpio_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [tpg_pkg::TPG_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [tpg_pkg::TPG_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [7:0] pin_in_a,
    input wire logic [7:0] pin_in_b,
    input wire logic [7:0] pin_in_c,
    output logic [7:0] pin_out_a,
    output logic [7:0] pin_out_b,
    output logic [7:0] pin_out_c,
    output logic [7:0] pin_oe_a,
    output logic [7:0] pin_oe_b,
    output logic [7:0] pin_oe_c,
    output logic [7:0] pullup_en_a,
    output logic [7:0] pullup_en_b,
    output logic [7:0] pullup_en_c,
    output logic [7:0] analog_sel_b,
    output logic port_irq_req,
    output logic [1:0] two_wire_serial_lines,
    output logic [2:0] display_channel_serial_lines,
    output logic horizontal_sync_in,
    output logic horizontal_drive_in,
    output logic power_in_line
);
    import tpg_pkg::*;

    // =====================================================================
    // Storage
    logic [7:0] regs_q [TPG_NUM_REGS];
    logic [23:0] pin_s1_q;
    logic [23:0] pin_s2_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [7:0] rdata_q;
    logic [TPG_ADDR_W-1:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    tpg_line_type [7:0] cfg_a;
    tpg_line_type [7:0] cfg_b;
    tpg_line_type [7:0] cfg_c;
    logic [7:0] out_a_q, out_b_q, out_c_q, oe_a_q, oe_b_q, oe_c_q;
    logic [7:0] pu_a_q, pu_b_q, pu_c_q, ana_b_q;
    logic irq_q;

    // =====================================================================
    // Pin synchroniser
    // two flop stages
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_q <= 24'h000000;
            pin_s2_q <= 24'h000000;
        end else begin
            pin_s1_q <= {pin_in_c, pin_in_b, pin_in_a};
            pin_s2_q <= pin_s1_q;
        end
    end

    // =====================================================================
    // Bus decode
    wire logic aw_fire = awvalid && awready_q;
    wire logic w_fire = wvalid && wready_q;
    wire logic ar_fire = arvalid && arready_q;
    wire logic commit = !awready_q && !wready_q && !bvalid_q;
    wire tpg_sel_type wr_sel = tpg_decode(awaddr_q);
    wire tpg_sel_type rd_sel = tpg_decode(araddr);
    wire logic rd_is_pin = (rd_sel.slot == TPG_SLOT_VALUE_A) ||
                           (rd_sel.slot == TPG_SLOT_VALUE_B) ||
                           (rd_sel.slot == TPG_SLOT_VALUE_C);
    wire logic [7:0] rd_pin = (rd_sel.slot == TPG_SLOT_VALUE_A) ? pin_s2_q[7:0] :
                              (rd_sel.slot == TPG_SLOT_VALUE_B) ? pin_s2_q[15:8] :
                              pin_s2_q[23:16];
    wire logic [7:0] rd_byte = !rd_sel.hit ? 8'h00 : rd_is_pin ? rd_pin : regs_q[rd_sel.slot];

    // Write address and data holding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            awaddr_q <= '0;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
        end else if (commit) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
        end else begin
            if (aw_fire) begin
                awready_q <= 1'b0;
                awaddr_q <= awaddr;
            end
            if (w_fire) begin
                wready_q <= 1'b0;
                wdata_q <= wdata[7:0];
                wstrb0_q <= wstrb[0];
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= TPG_RESP_OKAY;
        end else if (commit) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_sel.hit ? TPG_RESP_OKAY : TPG_RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // port C line two resets to output with value one, left high-Z
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < TPG_NUM_REGS; i++) begin
                regs_q[i] <= TPG_RST_ZERO;
            end
            regs_q[TPG_SLOT_VALUE_C] <= TPG_RST_VALUE_C;
            regs_q[TPG_SLOT_DIR_C] <= TPG_RST_DIR_C;
        end else if (commit && wr_sel.hit && wstrb0_q) begin
            regs_q[wr_sel.slot] <= wdata_q;
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= TPG_RESP_OKAY;
            rdata_q <= 8'h00;
        end else if (ar_fire) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= rd_sel.hit ? TPG_RESP_OKAY : TPG_RESP_SLVERR;
            rdata_q <= rd_byte;
        end else if (rvalid_q && rready) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
        end
    end

    // =====================================================================
    // Line configuration
    // each line decoded on its own
    // option bits only on A and B
    for (genvar i = 0; i < 8; i++) begin : g_line
        assign cfg_a[i] = tpg_line_cfg(regs_q[TPG_SLOT_DIR_A][i], regs_q[TPG_SLOT_OPT_A][i],
            regs_q[TPG_SLOT_VALUE_A][i], TPG_A_IRQ_MASK[i], TPG_A_PP_MASK[i],
            TPG_NONE_MASK[i], TPG_A_PU_MASK[i]);
        assign cfg_b[i] = tpg_line_cfg(regs_q[TPG_SLOT_DIR_B][i], regs_q[TPG_SLOT_OPT_B][i],
            regs_q[TPG_SLOT_VALUE_B][i], TPG_B_ALL_MASK[i], TPG_B_ALL_MASK[i],
            TPG_B_ALL_MASK[i], TPG_B_ALL_MASK[i]);
        assign cfg_c[i] = tpg_line_cfg(regs_q[TPG_SLOT_DIR_C][i], 1'b0,
            regs_q[TPG_SLOT_VALUE_C][i], 1'b0, 1'b0, 1'b0, TPG_C_PU_MASK[i]);
    end

    // Flattened fields of the line decode
    logic [7:0] d_out_a, d_out_b, d_out_c, d_oe_a, d_oe_b, d_oe_c;
    logic [7:0] d_pu_a, d_pu_b, d_pu_c, d_ana_b, d_irq_a, d_irq_b;
    for (genvar i = 0; i < 8; i++) begin : g_flat
        assign d_out_a[i] = cfg_a[i].out;
        assign d_out_b[i] = cfg_b[i].out;
        assign d_out_c[i] = cfg_c[i].out;
        assign d_oe_a[i] = cfg_a[i].oe;
        assign d_oe_b[i] = cfg_b[i].oe;
        assign d_oe_c[i] = cfg_c[i].oe;
        assign d_pu_a[i] = cfg_a[i].pu;
        assign d_pu_b[i] = cfg_b[i].pu;
        assign d_pu_c[i] = cfg_c[i].pu;
        assign d_ana_b[i] = cfg_b[i].ana;
        assign d_irq_a[i] = cfg_a[i].irq;
        assign d_irq_b[i] = cfg_b[i].irq;
    end

    // low level on an enabled line requests
    wire logic irq_d = |({d_irq_b, d_irq_a} & ~pin_s2_q[15:0]);

    // Registered pin drive, pull-ups, analog mux and request
    // pull-up or high-Z
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {out_a_q, out_b_q, out_c_q} <= 24'h000000;
            {oe_a_q, oe_b_q, oe_c_q} <= 24'h000000;
            {pu_a_q, pu_b_q, pu_c_q} <= 24'h000000;
            ana_b_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            {out_a_q, out_b_q, out_c_q} <= {d_out_a, d_out_b, d_out_c};
            {oe_a_q, oe_b_q, oe_c_q} <= {d_oe_a, d_oe_b, d_oe_c};
            {pu_a_q, pu_b_q, pu_c_q} <= {d_pu_a, d_pu_b, d_pu_c};
            ana_b_q <= d_ana_b;
            irq_q <= irq_d;
        end
    end

    // =====================================================================
    // Output wiring
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = {24'h000000, rdata_q};
    assign pin_out_a = out_a_q;
    assign pin_out_b = out_b_q;
    assign pin_out_c = out_c_q;
    assign pin_oe_a = oe_a_q;
    assign pin_oe_b = oe_b_q;
    assign pin_oe_c = oe_c_q;
    assign pullup_en_a = pu_a_q;
    assign pullup_en_b = pu_b_q;
    assign pullup_en_c = pu_c_q;
    assign analog_sel_b = ana_b_q;
    assign port_irq_req = irq_q;
    assign two_wire_serial_lines = pin_s2_q[7:6];
    assign display_channel_serial_lines = {pin_s2_q[19], pin_s2_q[17:16]};
    assign horizontal_sync_in = pin_s2_q[22];
    assign horizontal_drive_in = pin_s2_q[23];
    assign power_in_line = pin_s2_q[20];

    // =====================================================================
    // Assertions
    default clocking cb @(posedge aclk); endclocking

    property p_reset_state;
        !aresetn |=> (regs_q[TPG_SLOT_DIR_C] == TPG_RST_DIR_C) &&
            (regs_q[TPG_SLOT_VALUE_C] == TPG_RST_VALUE_C) &&
            (regs_q[TPG_SLOT_DIR_A] == TPG_RST_ZERO) && (regs_q[TPG_SLOT_OPT_B] == TPG_RST_ZERO);
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");

    property p_c2_idle;
        disable iff (!aresetn)
        $rose(aresetn) ##1 1'b1 |-> !pin_oe_c[2] && pullup_en_a == TPG_A_PU_MASK;
    endproperty
    a_c2_idle: assert property (p_c2_idle) else $error("line C2 not high-Z");

    property p_pin_read;
        disable iff (!aresetn)
        ar_fire && araddr == {2'h0, TPG_IDX_VALUE_A, 2'h0} |=> rdata[7:0] == $past(pin_in_a, 3);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("value read not pins");

    property p_irq_or;
        disable iff (!aresetn)
        |({d_irq_b, d_irq_a} & ~pin_s2_q[15:0]) |=> port_irq_req;
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("interrupt request missed");

    property p_analog;
        disable iff (!aresetn)
        !regs_q[TPG_SLOT_DIR_B][1] && regs_q[TPG_SLOT_OPT_B][1] && regs_q[TPG_SLOT_VALUE_B][1]
            |=> analog_sel_b[1] && !pullup_en_b[1] && !pin_oe_b[1];
    endproperty
    a_analog: assert property (p_analog) else $error("analog line not selected");

    property p_a7_od;
        disable iff (!aresetn)
        regs_q[TPG_SLOT_DIR_A][7] && regs_q[TPG_SLOT_OPT_A][7] && regs_q[TPG_SLOT_VALUE_A][7]
            |=> !pin_oe_a[7];
    endproperty
    a_a7_od: assert property (p_a7_od) else $error("line A7 driven high");

    property p_pushpull;
        disable iff (!aresetn)
        regs_q[TPG_SLOT_DIR_B][0] && regs_q[TPG_SLOT_OPT_B][0]
            |=> pin_oe_b[0] && pin_out_b[0] == $past(regs_q[TPG_SLOT_VALUE_B][0]);
    endproperty
    a_pushpull: assert property (p_pushpull) else $error("push-pull drive wrong");

    property p_a6_noirq;
        disable iff (!aresetn)
        !regs_q[TPG_SLOT_DIR_A][6] && regs_q[TPG_SLOT_OPT_A][6] |=> !pullup_en_a[6];
    endproperty
    a_a6_noirq: assert property (p_a6_noirq) else $error("A6 interrupt option taken");

    property p_pullup_code;
        disable iff (!aresetn)
        !regs_q[TPG_SLOT_DIR_A][0] && !regs_q[TPG_SLOT_OPT_A][0]
            |=> pullup_en_a[0] == !$past(regs_q[TPG_SLOT_VALUE_A][0]);
    endproperty
    a_pullup_code: assert property (p_pullup_code) else $error("code 00x pull-up wrong");

    property p_a_plain;
        disable iff (!aresetn)
        !regs_q[TPG_SLOT_DIR_A][3] && regs_q[TPG_SLOT_OPT_A][3] && regs_q[TPG_SLOT_VALUE_A][3]
            |=> !pullup_en_a[3] && !pin_oe_a[3];
    endproperty
    a_a_plain: assert property (p_a_plain) else $error("A3 code 011 not plain");

    property p_c_od;
        disable iff (!aresetn)
        regs_q[TPG_SLOT_DIR_C][5] && !regs_q[TPG_SLOT_VALUE_C][5]
            |=> pin_oe_c[5] && !pin_out_c[5] && !pullup_en_c[5];
    endproperty
    a_c_od: assert property (p_c_od) else $error("port C not open-drain");

    property p_wr_resp;
        disable iff (!aresetn)
        aw_fire && w_fire && !bvalid_q |-> ##[1:2] bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");

    c_write: cover property (@(posedge aclk) commit && wr_sel.hit);
    c_read: cover property (@(posedge aclk) ar_fire && rd_sel.hit);
    c_irq: cover property (@(posedge aclk) $rose(port_irq_req));
    c_unmapped: cover property (@(posedge aclk) ar_fire && !rd_sel.hit);

endmodule : tpg_gpio_top

// ### dv/tpg_pin_model.sv
`timescale 1ns/1ps
// ==========================================================
// External pins: drivers, pull-ups, board drive, floating lines
module tpg_pin_model (
    input wire logic aclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    logic float_q = 1'b0;

    // Undriven, unpulled lines wander every cycle
    always @(posedge aclk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pullup_en[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = float_q ^ i[0];
            end
        end
    end
endmodule : tpg_pin_model

// ### dv/tpg_gpio_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the three-port line block
module tpg_gpio_tb_top;
    import tpg_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [TPG_ADDR_W-1:0] awaddr = '0;
    logic [TPG_ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, irq, hs, hd, pw;
    logic [1:0] bresp, rresp, twl;
    logic [31:0] rdata;
    logic [2:0] dcl;
    logic [7:0] ana, d;
    logic [7:0] pi [3], po [3], poe [3], pue [3];
    logic [7:0] ev [3] = '{8'h00, 8'h00, 8'h00};
    logic [7:0] ee [3] = '{8'h00, 8'h00, 8'h00};
    int n_errors = 0;
    int num_checks = 0;

    always #25 aclk = ~aclk;

    // ==========================================================
    // Design and pin models
    tpg_gpio_top u_tpg_gpio_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pin_in_a(pi[0]), .pin_in_b(pi[1]), .pin_in_c(pi[2]),
        .pin_out_a(po[0]), .pin_out_b(po[1]), .pin_out_c(po[2]), .pin_oe_a(poe[0]),
        .pin_oe_b(poe[1]), .pin_oe_c(poe[2]), .pullup_en_a(pue[0]), .pullup_en_b(pue[1]),
        .pullup_en_c(pue[2]), .analog_sel_b(ana), .port_irq_req(irq),
        .two_wire_serial_lines(twl), .display_channel_serial_lines(dcl),
        .horizontal_sync_in(hs), .horizontal_drive_in(hd), .power_in_line(pw));

    for (genvar g = 0; g < 3; g++) begin : g_pins
        tpg_pin_model u_tpg_pin_model (.aclk(aclk), .pin_out(po[g]), .pin_oe(poe[g]),
            .pullup_en(pue[g]), .ext_val(ev[g]), .ext_en(ee[g]), .pin_in(pi[g]));
    end

    // ==========================================================
    // Shared checks, bus cycles and closing
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic tmo(input int n);
        if (n > 40) begin
            n_errors++;
            $display("Error at %0t: bus wait timed out", $time);
            tally_and_finish();
        end
    endtask : tmo

    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : ad

    task automatic wr(input logic [11:0] a, input logic [7:0] dv, input logic [1:0] er);
        int n;
        logic ta, tw;
        n = 0;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, dv};
        wstrb <= 4'h1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            n++;
            if (!ta && awready === 1'b1) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (!tw && wready === 1'b1) begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
            tmo(n);
        end
        ta = 1'b0;
        while (!ta) begin
            @(posedge aclk);
            n++;
            if (bvalid === 1'b1) begin
                ta = 1'b1;
                bready <= 1'b0;
                chk({6'h0, bresp}, {6'h0, er}, "write response");
            end
            tmo(n);
        end
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] dv, input logic [1:0] er);
        int n;
        logic ta, tr;
        n = 0;
        ta = 1'b0;
        tr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr) begin
            @(posedge aclk);
            n++;
            if (ta && rvalid === 1'b1) begin
                tr = 1'b1;
                rready <= 1'b0;
                dv = rdata[7:0];
                chk({6'h0, rresp}, {6'h0, er}, "read response");
                chk(rdata[15:8], 8'h00, "read upper bits");
            end
            if (!ta && arready === 1'b1) begin
                ta = 1'b1;
                arvalid <= 1'b0;
            end
            tmo(n);
        end
    endtask : rd

    task automatic settle();
        repeat (4) @(posedge aclk);
        #1;
    endtask : settle

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] ix [5];
        ix = '{TPG_IDX_DIR_A, TPG_IDX_DIR_B, TPG_IDX_DIR_C, TPG_IDX_OPT_A, TPG_IDX_OPT_B};
        settle();
        chk(pue[0], 8'h3f, "reset pull-ups a");
        chk(pue[1], 8'hff, "reset pull-ups b");
        chk(pue[2], 8'hf8, "reset pull-ups c");
        chk(poe[0] | poe[1] | poe[2] | ana, 8'h00, "reset drive");
        chk({7'h0, irq}, 8'h00, "reset request");
        for (int k = 0; k < 5; k++) begin
            rd(ad(ix[k]), d, TPG_RESP_OKAY);
            chk(d, (k == 2) ? 8'h04 : 8'h00, "reset register");
        end
        for (int k = 0; k < 5; k++) begin
            wr(ad(ix[k]), 8'h5a ^ 8'(k), TPG_RESP_OKAY);
            rd(ad(ix[k]), d, TPG_RESP_OKAY);
            chk(d, 8'h5a ^ 8'(k), "register readback");
        end
        wr(12'h31c, 8'h11, TPG_RESP_SLVERR);
        rd(12'h301, d, TPG_RESP_SLVERR);
        chk(d, 8'h00, "unmapped read data");
    endtask : t_reset

    task automatic t_outputs();
        ee[0] <= 8'h00;
        ee[1] <= 8'h00;
        wr(ad(TPG_IDX_DIR_B), 8'hff, TPG_RESP_OKAY);
        wr(ad(TPG_IDX_OPT_B), 8'h0f, TPG_RESP_OKAY);
        wr(ad(TPG_IDX_VALUE_B), 8'ha5, TPG_RESP_OKAY);
        settle();
        chk(poe[1], 8'h5f, "mixed drive enables");
        chk(po[1], 8'h05, "mixed drive levels");
        wr(ad(TPG_IDX_DIR_A), 8'hff, TPG_RESP_OKAY);
        wr(ad(TPG_IDX_OPT_A), 8'hff, TPG_RESP_OKAY);
        wr(ad(TPG_IDX_VALUE_A), 8'h00, TPG_RESP_OKAY);
        settle();
        chk(poe[0], 8'hff, "low level enables");
        chk(po[0], 8'h00, "low level drive");
        wr(ad(TPG_IDX_VALUE_A), 8'hff, TPG_RESP_OKAY);
        ee[0] <= 8'hc0;
        ev[0] <= 8'hc0;
        settle();
        chk(poe[0], 8'h3f, "high level enables");
        chk(po[0], 8'h3f, "high level drive");
        rd(ad(TPG_IDX_VALUE_A), d, TPG_RESP_OKAY);
        chk(d, 8'hff, "output pin readback");
    endtask : t_outputs

    task automatic t_inputs();
        ee[0] <= 8'hff;
        ev[0] <= 8'hff;
        ee[1] <= 8'hff;
        ev[1] <= 8'hff;
        wr(ad(TPG_IDX_DIR_A), 8'h00, TPG_RESP_OKAY);
        wr(ad(TPG_IDX_DIR_B), 8'h00, TPG_RESP_OKAY);
        wr(ad(TPG_IDX_OPT_A), 8'h4c, TPG_RESP_OKAY);
        wr(ad(TPG_IDX_VALUE_A), 8'h0a, TPG_RESP_OKAY);
        wr(ad(TPG_IDX_OPT_B), 8'h03, TPG_RESP_OKAY);
        wr(ad(TPG_IDX_VALUE_B), 8'h02, TPG_RESP_OKAY);
        settle();
        chk(pue[0], 8'h35, "input pull-ups a");
        chk(pue[1], 8'hfd, "input pull-ups b");
        chk(ana, 8'h02, "analog route");
        chk(poe[0] | poe[1], 8'h00, "inputs undriven");
        ev[0] <= 8'hb5;
        settle();
        chk({7'h0, irq}, 8'h00, "no request lines");
        ev[0] <= 8'hfb;
        settle();
        chk({7'h0, irq}, 8'h01, "request from a2");
        ev[0] <= 8'hff;
        settle();
        chk({7'h0, irq}, 8'h00, "request released");
        ev[1] <= 8'hfe;
        settle();
        chk({7'h0, irq}, 8'h01, "request from b0");
        rd(ad(TPG_IDX_VALUE_B), d, TPG_RESP_OKAY);
        chk(d, 8'hfe, "input pin readback");
    endtask : t_inputs

    task automatic t_port_c();
        ee[2] <= 8'h00;
        wr(ad(TPG_IDX_DIR_C), 8'hf0, TPG_RESP_OKAY);
        wr(ad(TPG_IDX_VALUE_C), 8'h00, TPG_RESP_OKAY);
        settle();
        chk(poe[2], 8'hf0, "c drive enables");
        chk(po[2], 8'h00, "c open-drain level");
        chk(pue[2], 8'h0c, "c pull-ups");
        wr(ad(TPG_IDX_DIR_C), 8'h00, TPG_RESP_OKAY);
        wr(ad(TPG_IDX_VALUE_C), 8'hff, TPG_RESP_OKAY);
        ee[2] <= 8'hff;
        ev[2] <= 8'h49;
        ev[0] <= 8'h80;
        settle();
        chk(pue[2], 8'h00, "c pull-ups off");
        chk({5'h0, dcl}, 8'h05, "display serial lines");
        chk({6'h0, twl}, 8'h02, "two-wire lines");
        chk({5'h0, hs, hd, pw}, 8'h04, "timing and power inputs");
        rd(ad(TPG_IDX_VALUE_C), d, TPG_RESP_OKAY);
        chk(d, 8'h49, "c pin readback");
    endtask : t_port_c

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_outputs();
        t_inputs();
        t_port_c();
        tally_and_finish();
    end
endmodule : tpg_gpio_tb_top
